// [smpsc_defs.vh]
// Constants of the switch MII port: register map, field positions, timing.
// Assumes a 100 MHz system clock and an AHB-Lite bus with 32-bit data.
`ifndef SMPSC_DEFS_VH
`define SMPSC_DEFS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define SMPSC_A_CTRL      8'h00
`define SMPSC_A_STATUS    8'h04
`define SMPSC_A_TXDATA    8'h08
`define SMPSC_A_FRAME     8'h0C
`define SMPSC_A_GOOD      8'h10
`define SMPSC_A_DROP      8'h14
`define SMPSC_A_ERR       8'h18
`define SMPSC_A_COLL      8'h1C

// ****************************************************************
// Field positions
// ****************************************************************
`define SMPSC_CTRL_MAC    0
`define SMPSC_CTRL_TXEN   1
`define SMPSC_TXD_LAST    8
`define SMPSC_ST_FBO      4
`define SMPSC_ST_FULL     5
`define SMPSC_ST_BUSY     6
`define SMPSC_ST_DONE     7
`define SMPSC_FR_TAG      16
`define SMPSC_FR_DROP     17
`define SMPSC_FR_ERR      18
`define SMPSC_CTRL_RST    2'h0

// ****************************************************************
// Frame size limits in bytes
// ****************************************************************
`define SMPSC_MAX_LONG    16'h0600
`define SMPSC_MAX_TAGGED  16'h05F2
`define SMPSC_MAX_UNTAG   16'h05EE
`define SMPSC_TPID_HI     8'h81
`define SMPSC_TPID_LO     8'h00
`define SMPSC_TPID_POS_HI 16'h000C
`define SMPSC_TPID_POS_LO 16'h000D

// ****************************************************************
// Timing
// ****************************************************************
`define SMPSC_SYS_HZ      100000000
`define SMPSC_NIB100_HZ   25000000
`define SMPSC_NIB10_HZ    2500000
`define SMPSC_HALF100     (`SMPSC_SYS_HZ / (2 * `SMPSC_NIB100_HZ))
`define SMPSC_HALF10      (`SMPSC_SYS_HZ / (2 * `SMPSC_NIB10_HZ))
`define SMPSC_SLOT_STD    11'h080
`define SMPSC_SLOT_FAST   11'h020
`define SMPSC_STRAP_WAIT  2'h3

`endif

// [smpsc_defs_unused_guard_note.v]
`default_nettype none
`default_nettype wire

// [smpsc_partner.sv]
// Partner model: an external MAC on the switch MII port.
// Assumes the bench resolves each clock and data wire from every enable.
`default_nettype none
module smpsc_partner (
  input  wire logic       txc,
  input  wire logic       rxc,
  input  wire logic       rx_valid,
  input  wire logic [3:0] rx_nib,
  output logic            pclk,
  output logic            tx_en,
  output logic            tx_er,
  output logic      [3:0] tx_nib
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       run;
  logic       half;
  logic [3:0] lo;
  logic [7:0] rx_q[$];

  // ********
  // Link clock and frame sender
  // ********
  // Own clock runs only within frames and stands low between them
  initial begin
    pclk = 1'b0;
    run = 1'b0;
    half = 1'b0;
    lo = 4'h0;
    tx_en = 1'b0;
    tx_er = 1'b0;
    tx_nib = 4'h0;
    #3;
    forever #40 pclk = run ? ~pclk : 1'b0;
  end

  // Bytes go out low nibble first, launched on the falling clock edge
  task automatic send(input int len, input bit tag, input bit err);
    logic [7:0] b;
    run = 1'b1;
    for (int i = 0; i < len; i++) begin
      b = (tag && i == 12) ? 8'h81 : (tag && i == 13) ? 8'h00 : 8'(i) ^ 8'h5A;
      for (int k = 0; k < 2; k++) begin
        @(negedge txc);
        tx_en  <= 1'b1;
        tx_er  <= err;
        tx_nib <= k ? b[7:4] : b[3:0];
      end
    end
    @(negedge txc);
    tx_en  <= 1'b0;
    tx_er  <= 1'b0;
    tx_nib <= 4'h0; // Pins pulled down once released
    repeat (6) @(negedge txc);
    run = 1'b0;
  endtask

  // Gathers egress bytes at the rising edge of the receive clock
  always @(posedge rxc) begin
    if (rx_valid === 1'b1) begin
      if (half) rx_q.push_back({rx_nib, lo});
      else lo = rx_nib;
      half = ~half;
    end else begin
      half = 1'b0;
    end
  end
endmodule
`default_nettype wire

// [smpsc_port.v]
// Switch MII port: nibble link, strap capture and AHB-Lite register file.
// Assumes one 100 MHz clock; link clocks are sampled pins, two-way pins are
// split into input, output and output enable.
//
// Summary of operation
// - While rst_n is low every flip-flop except the egress buffer storage is held at its reset value.
// - The core runs from one reference clock and derives nibble clocks by division in PHY mode; MAC mode samples the clock pins.
// - A high fast back-off input shortens the collision back-off slot.
// - The transmit clock pin is driven in PHY mode and taken as input in MAC mode.
// - The receive clock pin is driven in PHY mode and taken as input in MAC mode.
// - Outgoing frames leave as nibbles on the receive data pins with valid high.
// - Collision and carrier sense are driven for a half-duplex partner.
// - The bit 3 strap is captured and shown in status but does not enable flow control.
// - The bit 2 strap selects half duplex when pulled up, full when down.
// - The bit 1 strap selects 10 Mbps when pulled up, 100 Mbps when down.
// - With the bit 0 strap down, frames up to 1536 bytes pass and longer drop.
// - With the bit 0 strap up, limits are 1522 bytes tagged and 1518 untagged.
// - Strap pins are inputs during reset and become outputs after the capture.
//
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
`include "smpsc_defs.vh"
`default_nettype none

module smpsc_port #(
  parameter BO_SLOT_FAST = `SMPSC_SLOT_FAST
) (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output reg  [31:0] hrdata,
  output wire        hresp,
  input  wire        fast_backoff_sel,
  input  wire        port_tx_clock_i,
  output wire        port_tx_clock_o,
  output wire        port_tx_clock_oe,
  input  wire        port_rx_clock_i,
  output wire        port_rx_clock_o,
  output wire        port_rx_clock_oe,
  input  wire        port_tx_enable,
  input  wire        port_tx_error,
  input  wire [3:0]  port_tx_nibble,
  input  wire [3:0]  port_rx_nibble_i,
  output reg  [3:0]  port_rx_nibble_o,
  output wire        port_rx_nibble_oe,
  output reg         port_rx_valid,
  output reg         port_collision,
  output wire        port_collision_oe,
  output reg         port_carrier_sense,
  output wire        port_carrier_sense_oe
);

  localparam S_IDLE = 2'h0;
  localparam S_HI   = 2'h1;
  localparam S_SKIP = 2'h2;
  localparam S_WAIT = 2'h3;

  // Saturating 16-bit increment
  function [15:0] inc16;
    input [15:0] v;
    begin
      inc16 = (v == 16'hFFFF) ? v : v + 16'h0001;
    end
  endfunction

  // ****************************************************************
  // Strap capture and pin direction
  // ****************************************************************
  reg [3:0] strap_s1, strap_s2, straps;
  reg [1:0] strap_cnt;
  reg       strap_done;
  wire      flowctl_en = straps[3];
  wire      half_dpx   = straps[2];
  wire      speed10    = straps[1];
  wire      size_strict = straps[0];
  reg [1:0] ctrl;
  wire      mac_mode   = ctrl[`SMPSC_CTRL_MAC];

  // Sample the pulled pins while the outputs are still off
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_s1   <= 4'h0;
      strap_s2   <= 4'h0;
      straps     <= 4'h0;
      strap_cnt  <= 2'h0;
      strap_done <= 1'b0;
    end else begin
      strap_s1 <= port_rx_nibble_i;
      strap_s2 <= strap_s1;
      if (!strap_done) begin
        if (strap_cnt == `SMPSC_STRAP_WAIT) begin
          straps     <= strap_s2;
          strap_done <= 1'b1;
        end else begin
          strap_cnt <= strap_cnt + 2'h1;
        end
      end
    end
  end

  // Dual-purpose pins drive only after the straps are held
  assign port_rx_nibble_oe     = strap_done;
  assign port_collision_oe     = strap_done;
  assign port_carrier_sense_oe = strap_done;
  assign port_tx_clock_oe      = strap_done & ~mac_mode;
  assign port_rx_clock_oe      = strap_done & ~mac_mode;

  // ****************************************************************
  // Nibble clock divider for PHY mode
  // ****************************************************************
  reg [4:0] div_cnt;
  reg       div_clk;
  wire [31:0] div_half_w = speed10 ? `SMPSC_HALF10 : `SMPSC_HALF100;
  wire [4:0]  div_half   = div_half_w[4:0];

  // Derive the nibble clock from the reference clock
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 5'h00;
      div_clk <= 1'b0;
    end else if (div_cnt >= div_half - 5'h01) begin
      div_cnt <= 5'h00;
      div_clk <= ~div_clk;
    end else begin
      div_cnt <= div_cnt + 5'h01;
    end
  end

  assign port_tx_clock_o = div_clk;
  assign port_rx_clock_o = div_clk;

  // ****************************************************************
  // Synchronisers and clock edge detection
  // ****************************************************************
  reg [7:0] sy1, sy2;
  reg       txc_d, rxc_d;
  wire      txc_lvl = mac_mode ? port_tx_clock_i : div_clk;
  wire      rxc_lvl = mac_mode ? port_rx_clock_i : div_clk;
  wire      tx_edge = sy2[0] & ~txc_d;
  wire      rx_edge = sy2[1] & ~rxc_d;
  wire      en_s    = sy2[2];
  wire      er_s    = sy2[3];
  wire [3:0] nib_s  = sy2[7:4];
  reg       fbo_s1, fbo_s2;

  // Clocks and data share one delay so they stay aligned
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sy1    <= 8'h00;
      sy2    <= 8'h00;
      txc_d  <= 1'b0;
      rxc_d  <= 1'b0;
      fbo_s1 <= 1'b0;
      fbo_s2 <= 1'b0;
    end else begin
      sy1    <= {port_tx_nibble, port_tx_error, port_tx_enable, rxc_lvl, txc_lvl};
      sy2    <= sy1;
      txc_d  <= sy2[0];
      rxc_d  <= sy2[1];
      fbo_s1 <= fast_backoff_sel;
      fbo_s2 <= fbo_s1;
    end
  end

  // ****************************************************************
  // Ingress: partner nibbles into bytes, size check, statistics
  // ****************************************************************
  reg        en_d, nib_hi, frm_err, frm_tag;
  reg [3:0]  lo_nib;
  reg [15:0] frm_len, last_len, good_cnt, drop_cnt, err_cnt;
  reg        last_tag, last_drop, last_err;
  wire [7:0] cur_byte = {nib_s, lo_nib};
  wire [15:0] size_max = !size_strict ? `SMPSC_MAX_LONG :
                         (frm_tag ? `SMPSC_MAX_TAGGED : `SMPSC_MAX_UNTAG);

  // Sample on each rising transmit clock edge
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_d <= 1'b0;
      nib_hi <= 1'b0;
      frm_err <= 1'b0;
      frm_tag <= 1'b0;
      lo_nib <= 4'h0;
      frm_len <= 16'h0000;
      last_len <= 16'h0000;
      last_tag <= 1'b0;
      last_drop <= 1'b0;
      last_err <= 1'b0;
      good_cnt <= 16'h0000;
      drop_cnt <= 16'h0000;
      err_cnt <= 16'h0000;
    end else if (tx_edge) begin
      en_d <= en_s;
      if (en_s) begin
        if (er_s)
          frm_err <= 1'b1;
        nib_hi <= ~nib_hi;
        if (!nib_hi) begin
          lo_nib <= nib_s;
        end else begin
          frm_len <= inc16(frm_len);
          if (frm_len == `SMPSC_TPID_POS_HI)
            frm_tag <= (cur_byte == `SMPSC_TPID_HI);
          else if (frm_len == `SMPSC_TPID_POS_LO)
            frm_tag <= frm_tag & (cur_byte == `SMPSC_TPID_LO);
        end
      end else if (en_d) begin
        // Frame end: classify and reset the assembler
        last_len  <= frm_len;
        last_tag  <= frm_tag;
        last_err  <= frm_err;
        last_drop <= frm_len > size_max;
        if (frm_err)
          err_cnt <= inc16(err_cnt);
        else if (frm_len > size_max)
          drop_cnt <= inc16(drop_cnt);
        else
          good_cnt <= inc16(good_cnt);
        frm_len <= 16'h0000;
        frm_err <= 1'b0;
        frm_tag <= 1'b0;
        nib_hi  <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Two-entry egress buffer (software to link)
  // ****************************************************************
  reg [8:0] buf_mem [0:1];
  reg       wp, rp;
  reg [1:0] buf_cnt;
  wire      buf_full  = (buf_cnt == 2'h2);
  wire      buf_valid = (buf_cnt != 2'h0);
  wire [8:0] buf_head = buf_mem[rp];
  wire      buf_push;
  wire      buf_pop;

  // Pointers and occupancy; push and pop may coincide
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= 1'b0;
      rp <= 1'b0;
      buf_cnt <= 2'h0;
    end else begin
      if (buf_push)
        wp <= ~wp;
      if (buf_pop)
        rp <= ~rp;
      if (buf_push & ~buf_pop)
        buf_cnt <= buf_cnt + 2'h1;
      else if (buf_pop & ~buf_push)
        buf_cnt <= buf_cnt - 2'h1;
    end
  end

  // Storage needs no reset
  always @(posedge sys_clk) begin
    if (buf_push)
      buf_mem[wp] <= hwdata[8:0];
  end

  // ****************************************************************
  // Egress serializer onto the receive data pins
  // ****************************************************************
  reg [1:0]  st;
  reg [3:0]  hi_nib;
  reg        hi_last;
  reg [10:0] bo_cnt;
  reg [7:0]  lfsr;
  reg [15:0] coll_cnt;
  wire       col_now = half_dpx & en_s & port_rx_valid;
  wire [10:0] bo_slot = fbo_s2 ? BO_SLOT_FAST[10:0] : `SMPSC_SLOT_STD;
  wire       can_pop = rx_edge & buf_valid;
  // Each byte leaves the buffer once: first byte, mid-frame byte or flushed byte
  wire       mid_pop = can_pop & (st == S_WAIT) & (bo_cnt == 11'h000);
  assign buf_pop = mid_pop | (can_pop & (st == S_SKIP |
                   ((st == S_IDLE) & ctrl[`SMPSC_CTRL_TXEN])));

  // Update outputs on each rising receive clock edge
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= S_IDLE;
      hi_nib <= 4'h0;
      hi_last <= 1'b0;
      bo_cnt <= 11'h000;
      lfsr <= 8'h01;
      coll_cnt <= 16'h0000;
      port_rx_nibble_o <= 4'h0;
      port_rx_valid <= 1'b0;
      port_collision <= 1'b0;
      port_carrier_sense <= 1'b0;
    end else begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      if (rx_edge) begin
        port_collision     <= col_now;
        port_carrier_sense <= half_dpx & (en_s | port_rx_valid);
        case (st)
          S_IDLE: begin
            if (buf_pop) begin
              port_rx_nibble_o <= buf_head[3:0];
              port_rx_valid    <= 1'b1;
              hi_nib  <= buf_head[7:4];
              hi_last <= buf_head[`SMPSC_TXD_LAST];
              st      <= S_HI;
            end else begin
              port_rx_valid <= 1'b0;
            end
          end
          S_HI: begin
            if (col_now) begin
              // Abort the frame and flush the rest of it
              port_rx_valid <= 1'b0;
              coll_cnt <= inc16(coll_cnt);
              bo_cnt   <= bo_slot << lfsr[1:0];
              st       <= hi_last ? S_WAIT : S_SKIP;
            end else begin
              port_rx_nibble_o <= hi_nib;
              st <= hi_last ? S_IDLE : S_WAIT;
              bo_cnt <= 11'h000;
            end
          end
          S_SKIP: begin
            port_rx_valid <= 1'b0;
            if (buf_pop & buf_head[`SMPSC_TXD_LAST])
              st <= S_WAIT;
          end
          S_WAIT: begin
            // Mid-frame: take next byte, else flush the frame; after collision: back off
            if (bo_cnt != 11'h000) begin
              bo_cnt <= bo_cnt - 11'h001;
              port_rx_valid <= 1'b0;
              if (bo_cnt == 11'h001)
                st <= S_IDLE;
            end else if (can_pop) begin
              port_rx_nibble_o <= buf_head[3:0];
              hi_nib  <= buf_head[7:4];
              hi_last <= buf_head[`SMPSC_TXD_LAST];
              st      <= S_HI;
            end else begin
              port_rx_valid <= 1'b0;
              st <= S_SKIP;
            end
          end
          default: st <= S_IDLE;
        endcase
      end
    end
  end
  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  reg        dp_wr;
  reg [7:0]  dp_addr;
  wire       take = hsel & hready & htrans[1];
  wire       tx_stall = dp_wr & (dp_addr == `SMPSC_A_TXDATA) & buf_full;
  wire       wr_go = dp_wr & ~tx_stall;
  assign hreadyout = ~tx_stall;
  assign hresp     = 1'b0;
  assign buf_push  = wr_go & (dp_addr == `SMPSC_A_TXDATA);

  // Address phase capture, control writes and registered read data
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dp_wr <= 1'b0;
      dp_addr <= 8'h00;
      ctrl <= `SMPSC_CTRL_RST;
      hrdata <= 32'h00000000;
    end else begin
      if (wr_go & (dp_addr == `SMPSC_A_CTRL))
        ctrl <= hwdata[1:0];
      if (hreadyout) begin
        dp_wr   <= take & hwrite;
        dp_addr <= haddr[7:0];
      end
      if (take & ~hwrite) begin
        case (haddr[7:0])
          `SMPSC_A_CTRL:   hrdata <= {30'h0, ctrl};
          `SMPSC_A_STATUS: hrdata <= {24'h0, strap_done, st != S_IDLE,
                                      buf_full, fbo_s2, straps};
          `SMPSC_A_FRAME:  hrdata <= {13'h0, last_err, last_drop, last_tag, last_len};
          `SMPSC_A_GOOD:   hrdata <= {16'h0, good_cnt};
          `SMPSC_A_DROP:   hrdata <= {16'h0, drop_cnt};
          `SMPSC_A_ERR:    hrdata <= {16'h0, err_cnt};
          `SMPSC_A_COLL:   hrdata <= {16'h0, coll_cnt};
          default:         hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Flow control strap is observed only in status; transfer size is not used at all
  wire unused_ok = flowctl_en & hsize[0];

endmodule

`default_nettype wire

// [smpsc_port_assertions.sv]
// Checker of the switch MII port pins: enables, egress timing, reset state.
// Assumes a bind to smpsc_port and a single clock domain.
`default_nettype none
module smpsc_chk #(
  parameter int BO_SLOT_FAST = 32
) (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       hreadyout,
  input wire logic       port_tx_enable,
  input wire logic       port_tx_clock_oe,
  input wire logic       port_rx_clock_i,
  input wire logic       port_rx_clock_o,
  input wire logic       port_rx_clock_oe,
  input wire logic [3:0] port_rx_nibble_o,
  input wire logic       port_rx_nibble_oe,
  input wire logic       port_rx_valid,
  input wire logic       port_collision,
  input wire logic       port_collision_oe,
  input wire logic       port_carrier_sense,
  input wire logic       port_carrier_sense_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] rxh;
  wire        rxc = port_rx_clock_oe ? port_rx_clock_o : port_rx_clock_i;
  wire        rx_recent = |(rxh[4:0] ^ rxh[5:1]);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ********
  // Receive clock history
  // ********
  // Egress pins may only move a few cycles after the receive clock moved
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) rxh <= 6'h00;
    else rxh <= {rxh[4:0], rxc};
  end

  AST_RST_QUIET: assert property ($rose(rst_n) |-> !port_rx_valid && !port_collision
    && !port_carrier_sense) else $error("egress pins active at reset release");
  AST_OE_LOW: assert property ($rose(rst_n) |-> (!port_rx_nibble_oe) [*4])
    else $error("strap pins driven before capture");
  AST_OE_RISES: assert property ($rose(rst_n) |-> ##[1:10] port_rx_nibble_oe)
    else $error("strap capture never completed");
  AST_OE_HOLD: assert property (port_rx_nibble_oe |=> port_rx_nibble_oe)
    else $error("data pin enable dropped outside reset");
  AST_CLK_OE_PAIR: assert property (port_tx_clock_oe == port_rx_clock_oe)
    else $error("clock pin enables differ");
  AST_CLK_OE_AFTER: assert property (port_tx_clock_oe |-> port_rx_nibble_oe)
    else $error("clock driven before strap capture");
  AST_SENSE_OE: assert property ((port_collision_oe == port_rx_nibble_oe)
    && (port_carrier_sense_oe == port_rx_nibble_oe)) else $error("sense pin enable wrong");
  AST_COL_CRS: assert property (port_collision |-> port_carrier_sense)
    else $error("collision without carrier sense");
  AST_VALID_MIN: assert property ($rose(port_rx_valid) |-> port_rx_valid [*4])
    else $error("valid shorter than one nibble");
  AST_VALID_ON_CLK: assert property ($changed(port_rx_valid) |-> rx_recent)
    else $error("valid moved without receive clock");
  AST_NIB_ON_CLK: assert property (port_rx_valid && $changed(port_rx_nibble_o)
    |-> rx_recent) else $error("nibble moved without receive clock");

  COV_EGRESS: cover property ($rose(port_rx_valid));
  COV_INGRESS: cover property ($rose(port_tx_enable));
  COV_WAIT: cover property (!hreadyout);
  COV_MAC: cover property (!port_tx_clock_oe && port_rx_nibble_oe);
endmodule

bind smpsc_port smpsc_chk #(.BO_SLOT_FAST(BO_SLOT_FAST)) u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .hreadyout(hreadyout),
  .port_tx_enable(port_tx_enable), .port_tx_clock_oe(port_tx_clock_oe),
  .port_rx_clock_i(port_rx_clock_i), .port_rx_clock_o(port_rx_clock_o),
  .port_rx_clock_oe(port_rx_clock_oe), .port_rx_nibble_o(port_rx_nibble_o),
  .port_rx_nibble_oe(port_rx_nibble_oe), .port_rx_valid(port_rx_valid),
  .port_collision(port_collision), .port_collision_oe(port_collision_oe),
  .port_carrier_sense(port_carrier_sense), .port_carrier_sense_oe(port_carrier_sense_oe)
);
`default_nettype wire

// [switch_mii_port_strap_config_tb.sv]
// Bench of the switch MII port: straps, frame sizes, egress buffer, pin modes.
// Assumes the partner model on the link and acts as the AHB-Lite master.
`include "smpsc_defs.vh"
`default_nettype none
module switch_mii_port_strap_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, rst_n, hsel, hwrite, fbo, strict;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  strap_lvl;
  logic [31:0] haddr, hwdata, rd;
  logic [7:0]  eb [6] = '{8'hA5, 8'h3C, 8'h11, 8'h22, 8'h33, 8'h44};
  int          miscompares = 0, check_count = 0, cyc = 0, n_good, n_drop, n_err, n;
  wire         hready, hresp, txc, rxc, rx_valid, p_clk, tx_en, tx_er;
  wire         tx_o, tx_oe, rx_o, rx_oe, rxd_oe, col, col_oe, crs, crs_oe;
  wire [3:0]   tx_nib, rxd, rxd_o;
  wire [31:0]  hrdata;

  // Wire levels resolved from every driver; straps act as pulls
  assign txc = tx_oe ? tx_o : p_clk;
  assign rxc = rx_oe ? rx_o : p_clk;
  assign rxd = rxd_oe ? rxd_o : strap_lvl;

  smpsc_port uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .fast_backoff_sel(fbo),
    .port_tx_clock_i(txc), .port_tx_clock_o(tx_o), .port_tx_clock_oe(tx_oe),
    .port_rx_clock_i(rxc), .port_rx_clock_o(rx_o), .port_rx_clock_oe(rx_oe),
    .port_tx_enable(tx_en), .port_tx_error(tx_er), .port_tx_nibble(tx_nib),
    .port_rx_nibble_i(rxd), .port_rx_nibble_o(rxd_o), .port_rx_nibble_oe(rxd_oe),
    .port_rx_valid(rx_valid), .port_collision(col), .port_collision_oe(col_oe),
    .port_carrier_sense(crs), .port_carrier_sense_oe(crs_oe)
  );

  smpsc_partner pm (
    .txc(txc), .rxc(rxc), .rx_valid(rx_valid), .rx_nib(rxd), .pclk(p_clk),
    .tx_en(tx_en), .tx_er(tx_er), .tx_nib(tx_nib)
  );

  // ********
  // Clock, timeout and shared tasks
  // ********
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Cuts a hang short
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 90000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
  endtask

  task automatic do_reset(input logic [3:0] s, input logic f);
    rst_n     <= 1'b0;
    strap_lvl <= s;
    fbo       <= f;
    strict = s[0];
    n_good = 0;
    n_drop = 0;
    n_err = 0;
    pm.rx_q.delete();
    repeat (12) @(posedge sys_clk);
    chk(32'({hready, rxd_oe, tx_oe, rx_oe, col_oe, crs_oe, rx_valid}), 32'h40);
    rst_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
    ahb(`SMPSC_A_STATUS, 1'b0, 32'h0);
    chk(rd, {24'h0, 3'h4, f, s});
  endtask

  task automatic frame(input int len, input bit tag, input bit err);
    logic [15:0] lim;
    logic        ov;
    lim = !strict ? `SMPSC_MAX_LONG : tag ? `SMPSC_MAX_TAGGED : `SMPSC_MAX_UNTAG;
    ov = len > lim;
    if (err) n_err++;
    else if (ov) n_drop++;
    else n_good++;
    pm.send(len, tag, err);
    repeat (4) @(posedge sys_clk);
    ahb(`SMPSC_A_FRAME, 1'b0, 32'h0);
    chk(rd, {13'h0, err, ov, tag, 16'(len)});
    ahb(`SMPSC_A_GOOD, 1'b0, 32'h0);
    chk(rd, 32'(n_good));
    ahb(`SMPSC_A_DROP, 1'b0, 32'h0);
    chk(rd, 32'(n_drop));
    ahb(`SMPSC_A_ERR, 1'b0, 32'h0);
    chk(rd, 32'(n_err));
  endtask

  // Counts the high time of the driven transmit clock
  task automatic half_check(input int exp);
    @(posedge tx_o);
    n = 0;
    @(negedge sys_clk);
    while (tx_o === 1'b1) begin
      n++;
      @(negedge sys_clk);
    end
    chk(32'(n), 32'(exp));
    @(posedge sys_clk);
  endtask

  // ********
  // Scenarios
  // ********
  task automatic test_straps();
    do_reset(4'h0, 1'b1);
    chk(32'({rxd_oe, tx_oe, rx_oe}), 32'h7);
    ahb(`SMPSC_A_CTRL, 1'b0, 32'h0);
    chk(rd, 32'h0);
    ahb(8'h20, 1'b0, 32'h0);
    chk(rd, 32'h0);
    ahb(`SMPSC_A_STATUS, 1'b1, 32'hFF);
    ahb(`SMPSC_A_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h90);
    half_check(`SMPSC_HALF100);
    $display("test straps done");
  endtask

  task automatic test_egress();
    for (int i = 0; i < 2; i++) ahb(`SMPSC_A_TXDATA, 1'b1, {24'h0, eb[i]});
    ahb(`SMPSC_A_STATUS, 1'b0, 32'h0);
    chk(rd & 32'h20, 32'h20);
    ahb(`SMPSC_A_CTRL, 1'b1, 32'h2);
    for (int i = 2; i < 6; i++) ahb(`SMPSC_A_TXDATA, 1'b1, {23'h0, i == 5, eb[i]});
    n = 0;
    while (pm.rx_q.size() < 6 && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    chk(32'(pm.rx_q.size()), 32'h6);
    foreach (eb[i]) chk(32'(pm.rx_q[i]), 32'(eb[i]));
    repeat (40) @(posedge sys_clk);
    chk(32'(rx_valid), 32'h0);
    ahb(`SMPSC_A_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h90);
    $display("test egress done");
  endtask

  task automatic test_sizes();
    frame(1536, 1'b0, 1'b0);
    frame(1537, 1'b0, 1'b0);
    frame(64, 1'b1, 1'b0);
    frame(20, 1'b0, 1'b1);
    do_reset(4'h9, 1'b0);
    frame(1522, 1'b1, 1'b0);
    frame(1523, 1'b1, 1'b0);
    frame(1519, 1'b0, 1'b0);
    $display("test sizes done");
  endtask

  task automatic test_mac();
    do_reset(4'h6, 1'b0);
    half_check(`SMPSC_HALF10);
    ahb(`SMPSC_A_CTRL, 1'b1, 32'h1);
    repeat (4) @(posedge sys_clk);
    chk(32'({tx_oe, rx_oe, rxd_oe}), 32'h1);
    fork
      frame(64, 1'b0, 1'b0);
      begin
        repeat (300) @(posedge sys_clk);
        chk(32'(crs), 32'h1);
        chk(32'(col), 32'h0);
      end
    join
    $display("test mac done");
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    hsel = 1'b1;
    hsize = 3'h2;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    fbo = 1'b0;
    strap_lvl = 4'h0;
    strict = 1'b0;
    test_straps();
    test_egress();
    test_sizes();
    test_mac();
    summarize();
  end
endmodule
`default_nettype wire
